// ---- pic_pkg.sv ----
// Package for the priority interrupt controller: map, fields, types
package pic_pkg;

  // ==========================================================
  // Sizes
  // ==========================================================
  localparam int unsigned NUM_CH    = 32;      // Request channels
  localparam int unsigned NUM_LVL   = 8;       // Priority levels
  localparam int unsigned STACK_D   = 8;       // Nesting stack depth
  localparam int unsigned ADR_W     = 12;      // Byte address width

  // Channels that carry a defined source; channel 0 and reserved ones are 0
  localparam logic [31:0] VALID_CH  = 32'hfe5ffe4e;

  // ==========================================================
  // Register map (byte offsets)
  // ==========================================================
  localparam logic [11:0] OFS_SRC_CTRL  = 12'h000; // 32 words, one per channel
  localparam logic [11:0] OFS_RAW_STAT  = 12'h100; // Synchronised input levels
  localparam logic [11:0] OFS_PEND_STAT = 12'h104; // Active, unmasked and defined
  localparam logic [11:0] OFS_MASK      = 12'h108; // Mask state, 1 = enabled
  localparam logic [11:0] OFS_PRIO_ENC  = 12'h10c; // priority_encoding_reg
  localparam logic [11:0] OFS_MASK_EN   = 12'h110; // Write 1 enables a channel
  localparam logic [11:0] OFS_MASK_DIS  = 12'h114; // Write 1 disables a channel
  localparam logic [11:0] OFS_EOS       = 12'h118; // end_of_service_reg
  localparam logic [11:0] OFS_SRC_SET   = 12'h11c; // Set edge flags
  localparam logic [11:0] OFS_SRC_CLR   = 12'h120; // Clear edge flags
  localparam logic [11:0] OFS_CTRL      = 12'h124; // Bit 0 = debug mode
  localparam logic [11:0] OFS_LEVEL     = 12'h128; // Current level and depth

  // ==========================================================
  // Source control fields and reset value
  // ==========================================================
  localparam int unsigned SC_PRIO_LSB = 0;       // Priority [2:0]
  localparam int unsigned SC_TRIG_LSB = 6;       // Trigger type [7:6]
  localparam logic [7:0]  SC_RESET    = 8'h47;   // High level, level 7
  localparam logic [3:0]  LVL_IDLE    = 4'h8;    // No interrupt in service
  localparam int unsigned LEVEL_DEPTH_LSB = 8;   // Depth field in level word

  // Trigger types, in field order
  typedef enum logic [1:0] {TRIG_LOW, TRIG_HIGH, TRIG_FALL, TRIG_RISE} pic_trig_t;

  // Wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [11:0] adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } pic_wb_req_t;

  // Result of priority selection
  typedef struct packed {
    logic       found;
    logic [4:0] ch;
    logic [2:0] prio;
  } pic_win_t;

  // Whole module state
  typedef struct packed {
    logic [31:0]       sync1;     // First synchroniser stage
    logic [31:0]       sync2;     // Second synchroniser stage
    logic [31:0]       prev;      // Previous level for edge detect
    logic [31:0]       edge_flg;  // Latched edge events
    logic [31:0]       mask;      // 1 = channel enabled
    logic [31:0][7:0]  src_ctrl;  // Per channel control
    logic [3:0]        cur_lvl;   // Current level, 8 = idle
    logic [7:0][3:0]   stack;     // Stacked levels
    logic [3:0]        depth;     // Stack fill
    logic              dbg;       // Debug mode
    pic_win_t          saved;     // Winner kept for debug write
    logic              ack;       // Wishbone ack
    logic [31:0]       rdat;      // Wishbone read data
    logic              irq_n;     // Normal request, active low
    logic              fiq_n;     // Fast request, active low
  } pic_state_t;

endpackage

// ---- pic_ctrl.sv ----
// Priority interrupt controller with Wishbone register port
//
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/1ps

module pic_ctrl
  import pic_pkg::*;
(
  // Clock and reset
  input  wire logic              CLK,
  input  wire logic              RESET,
  // Interrupt request inputs, one per channel
  input  wire logic [31:0]       SRC_REQ,
  // Wishbone slave
  input  wire pic_pkg::pic_wb_req_t WB_REQ,
  output logic                   WB_ACK,
  output logic [31:0]            WB_DAT,
  // Processor request lines
  output logic                   NORMAL_REQ_LINE_N,
  output logic                   FAST_REQ_LINE_N
);
  import pic_pkg::*;

  // ==========================================================
  // Functions
  // ==========================================================
  // Highest level wins, lowest channel first inside a level
  function automatic pic_win_t pick(input logic [31:0] pend,
                                    input logic [31:0][7:0] sc);
    pic_win_t w;
    w = '{found: 1'b0, ch: 5'h00, prio: 3'h7};
    for (int i = 0; i < NUM_CH; i++)
    begin
      // Strict compare keeps the earlier, lower channel on a tie
      if (pend[i] && (!w.found || sc[i][SC_PRIO_LSB +: 3] < w.prio))
      begin
        w.found = 1'b1;
        w.ch    = 5'(i);
        w.prio  = sc[i][SC_PRIO_LSB +: 3];
      end
    end
    return w;
  endfunction

  // Byte enables spread to a bit mask
  function automatic logic [31:0] lanes(input logic [3:0] sel);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int b = 0; b < 4; b++)
    begin
      m[b*8 +: 8] = {8{sel[b]}};
    end
    return m;
  endfunction

  // ==========================================================
  // State and combinational helpers
  // ==========================================================
  pic_state_t  q;          // Registered state
  pic_state_t  d;          // Next state
  logic [31:0] active;     // Sources requesting after trigger decode
  logic [31:0] pend;       // Active, unmasked and defined
  logic [31:0] irq_pend;   // Pending with level 1 to 7
  logic [31:0] fiq_pend;   // Pending with level 0
  logic [31:0] wmask;      // Write byte lane mask
  logic [31:0] wdat;       // Write data under lanes
  logic [31:0] clr_ack;    // Edge flag cleared by acknowledge
  logic        req;        // New bus access this cycle
  logic        rd_enc;     // Read of encoding register
  logic        wr_enc;     // Write of encoding register
  logic        take;       // Acknowledge of the irq winner
  pic_win_t    win;        // Current irq winner
  pic_win_t    tw;         // Winner used on acknowledge
  logic        win_ok;     // Winner above current level

  // ==========================================================
  // Next state
  // ==========================================================
  // All decode, selection and bus work lives in this one process
  always_comb
  begin
    d        = q;
    clr_ack  = 32'h0000_0000;
    wmask    = lanes(WB_REQ.sel);
    wdat     = WB_REQ.dat & wmask;
    req      = WB_REQ.cyc && WB_REQ.stb && !q.ack;
    rd_enc   = req && !WB_REQ.we && (WB_REQ.adr == OFS_PRIO_ENC);
    wr_enc   = req && WB_REQ.we && (WB_REQ.adr == OFS_PRIO_ENC);

    // Two stages on every input, they come from other clock domains
    d.sync1  = SRC_REQ;
    d.sync2  = q.sync1;
    d.prev   = q.sync2;

    // Trigger decode; internal lines simply arrive high when requesting
    for (int i = 0; i < NUM_CH; i++)
    begin
      case (pic_trig_t'(q.src_ctrl[i][SC_TRIG_LSB +: 2]))
        TRIG_LOW:  active[i] = !q.sync2[i];
        TRIG_HIGH: active[i] = q.sync2[i];
        default:   active[i] = q.edge_flg[i];
      endcase
    end

    // Reserved channels and channel 0 are forced off
    pend     = active & q.mask & VALID_CH;
    for (int i = 0; i < NUM_CH; i++)
    begin
      fiq_pend[i] = pend[i] && (q.src_ctrl[i][SC_PRIO_LSB +: 3] == 3'h0);
      irq_pend[i] = pend[i] && (q.src_ctrl[i][SC_PRIO_LSB +: 3] != 3'h0);
    end
    win      = pick(irq_pend, q.src_ctrl);
    // Only a level above the one in service may request
    win_ok   = win.found && ({1'b0, win.prio} < q.cur_lvl);

    // Acknowledge: read in normal mode, write in debug mode
    take     = q.dbg ? (wr_enc && q.saved.found) : (rd_enc && win_ok);
    tw       = q.dbg ? q.saved : win;

    // Bus answer: one cycle ack, dropped the cycle after
    d.ack    = req;
    d.rdat   = 32'h0000_0000;
    if (req && !WB_REQ.we)
    begin
      if (WB_REQ.adr < OFS_RAW_STAT)
      begin
        d.rdat = {24'h00_0000, q.src_ctrl[WB_REQ.adr[6:2]]};
      end
      else if (WB_REQ.adr == OFS_RAW_STAT)
      begin
        d.rdat = q.sync2;
      end
      else if (WB_REQ.adr == OFS_PEND_STAT)
      begin
        d.rdat = pend;
      end
      else if (WB_REQ.adr == OFS_MASK)
      begin
        d.rdat = q.mask;
      end
      else if (WB_REQ.adr == OFS_PRIO_ENC)
      begin
        // Zero vector when nothing above the current level waits
        d.rdat = win_ok ? {25'h0, win.ch, 2'b00} : 32'h0000_0000;
      end
      else if (WB_REQ.adr == OFS_CTRL)
      begin
        d.rdat = {31'h0, q.dbg};
      end
      else if (WB_REQ.adr == OFS_LEVEL)
      begin
        d.rdat = {20'h0_0000, q.depth, 4'h0, q.cur_lvl};
      end
      else
      begin
        // Unmapped read answers zero
        d.rdat = 32'h0000_0000;
      end
    end

    // Debug mode keeps the winner for the later write
    if (rd_enc && q.dbg)
    begin
      d.saved = win_ok ? win : '{found: 1'b0, ch: 5'h00, prio: 3'h7};
    end

    // Register writes
    if (req && WB_REQ.we)
    begin
      if (WB_REQ.adr < OFS_RAW_STAT)
      begin
        if (WB_REQ.sel[0])
        begin
          d.src_ctrl[WB_REQ.adr[6:2]] = WB_REQ.dat[7:0];
        end
      end
      else if (WB_REQ.adr == OFS_MASK_EN)
      begin
        d.mask = q.mask | wdat;
      end
      else if (WB_REQ.adr == OFS_MASK_DIS)
      begin
        d.mask = q.mask & ~wdat;
      end
      else if (WB_REQ.adr == OFS_CTRL)
      begin
        if (WB_REQ.sel[0])
        begin
          d.dbg = WB_REQ.dat[0];
        end
      end
      else if (WB_REQ.adr == OFS_EOS)
      begin
        // Return to the interrupted level, or to idle when empty
        if (q.depth != 4'h0)
        begin
          d.cur_lvl = q.stack[3'(q.depth - 4'h1)];
          d.depth   = q.depth - 4'h1;
        end
      end
      else
      begin
        // Other writes change nothing here; edge set, edge clear and debug encoding writes act below
        d.mask = d.mask;
      end
    end

    // Acknowledge stacks the level and raises the current one
    if (take)
    begin
      // Depth never passes seven: each push is a strictly higher level
      if (q.depth < 4'(STACK_D))
      begin
        d.stack[3'(q.depth)] = q.cur_lvl;
        d.depth              = q.depth + 4'h1;
      end
      d.cur_lvl          = {1'b0, tw.prio};
      clr_ack[tw.ch]     = 1'b1;
      d.saved.found      = 1'b0;
    end

    // Edge flags: an edge in the clearing cycle is kept
    for (int i = 0; i < NUM_CH; i++)
    begin
      logic ev;
      logic clr;
      ev  = 1'b0;
      clr = clr_ack[i];
      if (q.src_ctrl[i][SC_TRIG_LSB +: 2] == 2'(TRIG_RISE))
      begin
        ev = q.sync2[i] && !q.prev[i];
      end
      else if (q.src_ctrl[i][SC_TRIG_LSB +: 2] == 2'(TRIG_FALL))
      begin
        ev = !q.sync2[i] && q.prev[i];
      end
      if (req && WB_REQ.we && (WB_REQ.adr == OFS_SRC_SET) && wdat[i])
      begin
        ev = 1'b1;
      end
      if (req && WB_REQ.we && (WB_REQ.adr == OFS_SRC_CLR) && wdat[i])
      begin
        clr = 1'b1;
      end
      d.edge_flg[i] = ev ? 1'b1 : (clr ? 1'b0 : q.edge_flg[i]);
    end

    // Fast line ignores the current level so it can preempt
    d.fiq_n  = !(|fiq_pend);
    // Normal line rises once the winner is taken, falls again on a higher one
    d.irq_n  = !(win_ok && !take);
  end

  // ==========================================================
  // State register
  // ==========================================================
  // Synchronous reset to constants only
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      q.sync1    <= 32'h0000_0000;
      q.sync2    <= 32'h0000_0000;
      q.prev     <= 32'h0000_0000;
      q.edge_flg <= 32'h0000_0000;
      q.mask     <= 32'h0000_0000;
      q.src_ctrl <= {NUM_CH{SC_RESET}};
      q.cur_lvl  <= LVL_IDLE;
      q.stack    <= '0;
      q.depth    <= 4'h0;
      q.dbg      <= 1'b0;
      q.saved    <= '{found: 1'b0, ch: 5'h00, prio: 3'h7};
      q.ack      <= 1'b0;
      q.rdat     <= 32'h0000_0000;
      q.irq_n    <= 1'b1;
      q.fiq_n    <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs straight from the state register
  // ==========================================================
  assign WB_ACK            = q.ack;
  assign WB_DAT            = q.rdat;
  assign NORMAL_REQ_LINE_N = q.irq_n;
  assign FAST_REQ_LINE_N   = q.fiq_n;

endmodule // pic_ctrl

// ---- pic_ctrl_asserts.sv ----
// Concurrent checks on the interrupt controller ports
`timescale 1ns/1ps

module pic_ctrl_asserts
  import pic_pkg::*;
(
  // Clock and reset
  input wire logic               CLK,
  input wire logic               RESET,
  // Requests and register bus
  input wire logic [31:0]        SRC_REQ,
  input wire pic_pkg::pic_wb_req_t WB_REQ,
  input wire logic               WB_ACK,
  input wire logic [31:0]        WB_DAT,
  // Processor lines
  input wire logic               NORMAL_REQ_LINE_N,
  input wire logic               FAST_REQ_LINE_N
);
  // ==========================================================
  // Helper logic
  // ==========================================================
  logic take;     // Request taken at this edge
  logic enc_rd_q; // Encoding read was taken last edge
  logic dbg_q;    // Debug mode as written over the bus
  assign take = WB_REQ.cyc && WB_REQ.stb && !WB_ACK;
  // Remember encoding reads and the debug bit so the answer cycle can be judged
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      enc_rd_q <= 1'b0;
      dbg_q    <= 1'b0;
    end
    else
    begin
      enc_rd_q <= take && !WB_REQ.we && (WB_REQ.adr == OFS_PRIO_ENC);
      // A read in debug mode only looks, so the line rules differ there
      if (take && WB_REQ.we && (WB_REQ.adr == OFS_CTRL) && WB_REQ.sel[0])
      begin
        dbg_q <= WB_REQ.dat[0];
      end
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // ==========================================================
  // Properties
  // ==========================================================
  a_ack_one_pulse: assert property (WB_ACK |=> !WB_ACK)
    else $error("ack held longer than one cycle");
  a_ack_answers: assert property (take |=> WB_ACK)
    else $error("request not answered next cycle");
  a_dat_quiet: assert property (!WB_ACK |-> WB_DAT == 32'h0)
    else $error("read data outside ack");
  a_enc_aligned: assert property (enc_rd_q |-> WB_ACK && WB_DAT[1:0] == 2'h0 && WB_DAT[31:7] == 25'h0)
    else $error("vector not word aligned");
  a_enc_valid_ch: assert property (enc_rd_q && WB_DAT != 32'h0 |-> VALID_CH[WB_DAT[6:2]])
    else $error("vector names an undefined channel");
  a_enc_drops_irq: assert property (enc_rd_q && !dbg_q && WB_DAT != 32'h0 |-> NORMAL_REQ_LINE_N)
    else $error("normal line still low after vector read");
  a_dbg_keeps_irq: assert property (enc_rd_q && dbg_q && WB_DAT != 32'h0 |-> !NORMAL_REQ_LINE_N)
    else $error("debug read acknowledged the winner");
  a_reset_lines: assert property ($fell(RESET) |-> (NORMAL_REQ_LINE_N && FAST_REQ_LINE_N) [*3])
    else $error("request line low after reset");
  a_reset_bus: assert property ($fell(RESET) |-> !WB_ACK && $stable(WB_DAT))
    else $error("bus busy after reset");
endmodule // pic_ctrl_asserts

bind pic_ctrl pic_ctrl_asserts pic_ctrl_asserts_i (.CLK(CLK), .RESET(RESET), .SRC_REQ(SRC_REQ),
  .WB_REQ(WB_REQ), .WB_ACK(WB_ACK), .WB_DAT(WB_DAT),
  .NORMAL_REQ_LINE_N(NORMAL_REQ_LINE_N), .FAST_REQ_LINE_N(FAST_REQ_LINE_N));

// ---- pic_cpu_model.sv ----
// Processor core model that counts request line assertions
`timescale 1ns/1ps

module pic_cpu_model
(
  // Clock and reset
  input wire logic  clk,
  input wire logic  rst,
  // Request lines, active low
  input wire logic  normal_n,
  input wire logic  fast_n,
  // Assertion counts
  output logic [7:0] irq_cnt,
  output logic [7:0] fiq_cnt
);
  logic nq; // Last normal level
  logic fq; // Last fast level
  // Count falling edges; a level held low counts once only
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq_cnt <= 8'h0;
      fiq_cnt <= 8'h0;
    end
    else
    begin
      irq_cnt <= irq_cnt + 8'(nq && !normal_n);
      fiq_cnt <= fiq_cnt + 8'(fq && !fast_n);
    end
    nq <= normal_n;
    fq <= fast_n;
  end
endmodule // pic_cpu_model

// ---- testbench.sv ----
// Self-checking bench for the priority interrupt controller
`timescale 1ns/1ps

module testbench;
  import pic_pkg::*;
  logic        CLK;            // System clock
  logic        RESET;          // Sync reset
  logic [31:0] SRC_REQ;        // Source levels
  pic_wb_req_t wb_req;         // Bus request
  logic        WB_ACK;         // Bus ack
  logic [31:0] WB_DAT;         // Read data
  logic        NORMAL_REQ_LINE_N;
  logic        FAST_REQ_LINE_N;
  logic [7:0]  irq_cnt;        // Model counts
  logic [7:0]  fiq_cnt;
  logic [31:0] r;              // Last read word
  int          error_cnt;
  int          samples_checked;

  pic_ctrl pic_ctrl_i (.CLK(CLK), .RESET(RESET), .SRC_REQ(SRC_REQ), .WB_REQ(wb_req),
    .WB_ACK(WB_ACK), .WB_DAT(WB_DAT), .NORMAL_REQ_LINE_N(NORMAL_REQ_LINE_N),
    .FAST_REQ_LINE_N(FAST_REQ_LINE_N));
  pic_cpu_model pic_cpu_model_i (.clk(CLK), .rst(RESET), .normal_n(NORMAL_REQ_LINE_N),
    .fast_n(FAST_REQ_LINE_N), .irq_cnt(irq_cnt), .fiq_cnt(fiq_cnt));

  // ==========================================================
  // Tasks
  // ==========================================================
  // One classic cycle; holds the request until ack, only the watchdog ends a hang
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    wb_req <= {1'b1, 1'b1, w, a, 4'hf, d};
    @(posedge CLK);
    while (WB_ACK !== 1'b1)
    begin
      @(posedge CLK);
    end
    r = WB_DAT;
    wb_req <= '0;
    @(posedge CLK);
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Lines see a source change after the two-flop synchroniser
  task automatic settle;
    repeat (6) @(posedge CLK);
  endtask

  // ==========================================================
  // Clock, watchdog, tests
  // ==========================================================
  initial
  begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  // Tests need a few thousand cycles at most
  initial
  begin
    #100000;
    error_cnt++;
    tally_and_finish;
  end
  initial
  begin
    error_cnt = 0;
    samples_checked = 0;
    RESET = 1'b1;
    SRC_REQ = 32'h0;
    wb_req = '0;
    repeat (3) @(posedge CLK);
    RESET <= 1'b0;
    @(posedge CLK);
    wb(0, 12'h004, 0); chk(r, 32'h47);
    wb(1, 12'h07c, 32'h46);
    wb(0, 12'h07c, 0); chk(r, 32'h46);
    wb(0, OFS_MASK, 0); chk(r, 32'h0);
    wb(0, OFS_LEVEL, 0); chk(r, 32'h8);
    wb(0, 12'h200, 0); chk(r, 32'h0);
    for (int c = 0; c < 32; c++) wb(1, 12'(c * 4), 32'h47);
    $display("test reset done");
    // Tie at level 3, a reserved channel, nesting at level 1
    wb(1, 12'h024, 32'h43);
    wb(1, 12'h028, 32'h43);
    wb(1, 12'h030, 32'h45);
    wb(1, OFS_MASK_EN, 32'h1610);
    SRC_REQ <= 32'h1610;
    settle;
    chk(NORMAL_REQ_LINE_N, 0);
    wb(0, OFS_PEND_STAT, 0); chk(r, 32'h1600);
    wb(0, OFS_PRIO_ENC, 0); chk(r, 32'h24);
    chk(NORMAL_REQ_LINE_N, 1);
    wb(0, OFS_LEVEL, 0); chk(r, 32'h103);
    wb(1, 12'h018, 32'h41);
    wb(1, OFS_MASK_EN, 32'h40);
    SRC_REQ <= 32'h1650;
    settle;
    chk(NORMAL_REQ_LINE_N, 0);
    wb(0, OFS_PRIO_ENC, 0); chk(r, 32'h18);
    wb(0, OFS_PRIO_ENC, 0); chk(r, 32'h0);
    wb(0, OFS_LEVEL, 0); chk(r, 32'h201);
    wb(1, OFS_EOS, 0);
    wb(0, OFS_LEVEL, 0); chk(r, 32'h103);
    wb(1, OFS_EOS, 0);
    wb(0, OFS_LEVEL, 0); chk(r, 32'h8);
    wb(1, OFS_MASK_DIS, 32'h240);
    wb(0, OFS_PRIO_ENC, 0); chk(r, 32'h28);
    chk(irq_cnt, 32'h3);
    $display("test priority done");
    // Fast request while a normal one is in service
    wb(1, 12'h008, 32'h40);
    wb(1, OFS_MASK_EN, 32'h4);
    SRC_REQ <= 32'h1654;
    settle;
    chk(FAST_REQ_LINE_N, 0);
    chk(NORMAL_REQ_LINE_N, 1);
    chk(fiq_cnt, 1);
    SRC_REQ <= 32'h0;
    settle;
    chk(FAST_REQ_LINE_N, 1);
    wb(1, OFS_EOS, 0);
    wb(1, OFS_MASK_DIS, 32'hffffffff);
    wb(1, OFS_MASK_EN, 32'h4000);
    $display("test fast done");
    // All four trigger types on one channel
    for (int t = 0; t < 4; t++)
    begin
      SRC_REQ[14] <= (t == 0 || t == 2);
      settle;
      wb(1, 12'h038, 32'({2'(t), 6'h07}));
      wb(1, OFS_SRC_CLR, 32'h4000);
      wb(0, OFS_PEND_STAT, 0); chk(r, 32'h0);
      SRC_REQ[14] <= !(t == 0 || t == 2);
      settle;
      wb(0, OFS_PEND_STAT, 0); chk(r, 32'h4000);
    end
    wb(0, OFS_PRIO_ENC, 0); chk(r, 32'h38);
    wb(0, OFS_PEND_STAT, 0); chk(r, 32'h0);
    wb(1, OFS_EOS, 0);
    $display("test triggers done");
    // Debug mode: a read only looks, the later write acknowledges
    wb(1, OFS_CTRL, 32'h1);
    wb(0, OFS_CTRL, 0); chk(r, 32'h1);
    wb(1, OFS_SRC_SET, 32'h4000);
    chk(NORMAL_REQ_LINE_N, 0);
    wb(0, OFS_PRIO_ENC, 0); chk(r, 32'h38);
    chk(NORMAL_REQ_LINE_N, 0);
    wb(0, OFS_LEVEL, 0); chk(r, 32'h8);
    wb(1, OFS_PRIO_ENC, 0);
    chk(NORMAL_REQ_LINE_N, 1);
    wb(0, OFS_LEVEL, 0); chk(r, 32'h107);
    wb(0, OFS_PEND_STAT, 0); chk(r, 32'h0);
    wb(1, OFS_EOS, 0);
    wb(1, OFS_CTRL, 32'h0);
    $display("test debug done");
    tally_and_finish;
  end
endmodule // testbench
